// File: rtl/usb_link_power_cfg_fields.sv
// APB register bank for the U1/LTM link power controls and the
// full-speed timeout trim, with the derived enables and timeout.
// Fields are stored in reload_field instances; fs_timeout_calc does the sum.
// Assumes a 60 MHz PHY clock and USB/lite resets synchronous to ref_clk.
// Assumes image inputs are stable whenever a reload request is high.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Self U1 entry needs bit and host feature
// - U1 initiate and accept bits act independently
// - Accept host U1 requests when accept bit set
// - LTM active exactly when its bit set
// - Protected reset leaves U1 and LTM bits alone
// - Timeout adds trim count times per-clock factor
// - Each trim count adds 0.2 bit time
// - Base full-speed timeout within 16 to 18
// - Outside full speed present high-speed trim
// - Only 60 MHz PHY clock supported
// - U1 initiate and LTM reload, default zero
// - U1 accept reloads, default one
module usb_link_power_cfg_fields #(
   parameter int FS_BASE_BITS = usb_link_power_pkg::FS_BASE_MIN_BITS,
   parameter int PHY_CLK_MHZ  = usb_link_power_pkg::PHY_CLK_MHZ
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Reset sources and protection
   input  wire logic        usb_reset,
   input  wire logic        lite_reset,
   input  wire logic        rst_protect,
   // Configuration image from EEPROM or OTP
   input  wire logic        image_valid,
   input  wire logic        image_u1_init,
   input  wire logic        image_u1_accept,
   input  wire logic        image_ltm,
   input  wire logic [2:0]  image_fs_trim,
   // Link state from the device controller
   input  wire logic        host_u1_feature_en,
   input  wire logic        fs_mode,
   input  wire logic [2:0]  highspeed_timeout_trim,
   // Controls to the device controller
   output logic             u1_initiate_permit,
   output logic             u1_host_accept,
   output logic             ltm_active,
   output logic      [2:0]  presented_timeout_trim,
   output logic      [7:0]  fs_timeout_tenths
);
   // Overview: four stored fields feed a registered control bundle for the
   // device controller and two read views on the APB side. Nothing here
   // counts time; the timeout is a static sum that the controller applies.

   // Only the 60 MHz PHY is handled; other rates fail elaboration.
   // The trim step is a whole number of tenths only at this rate, so a
   // quiet fallback to another rate would give a wrong timeout instead.
   if (PHY_CLK_MHZ != usb_link_power_pkg::PHY_CLK_MHZ) begin : g_phy_rate_check
      $error("PHY_CLK_MHZ other than 60 has no trim step");
   end

   // Register layout of usb_link_power_config:
   //   bit 10    u1_self_initiate_en        (protected, image or 0)
   //   bit 9     u1_host_request_accept_en  (protected, image or 1)
   //   bit 8     latency_tolerance_msg_en   (protected, image or 0)
   //   bit 7     reserved, reads zero
   //   bits 6:4  fullspeed_timeout_trim     (image or 0, never protected)
   //   bits 3:2  reserved, reads zero
   //   all other bits belong to neighbouring logic and read zero here
   // Field values
   logic                u1_self_initiate_en;        // Device may start U1
   logic                u1_host_request_accept_en;  // Host U1 requests accepted
   logic                latency_tolerance_msg_en;   // LTM function on
   logic [2:0]          fullspeed_timeout_trim;     // PHY clocks of extra timeout

   // Bus phase decode. The full 12-bit byte address is compared, so
   // unaligned or aliased addresses fall into the unmapped set.
   wire logic           access   = psel & penable;
   wire logic           rd_setup = psel & ~penable & ~pwrite;  // Read setup cycle
   wire logic           wr_xfer  = access & pwrite;
   wire logic           hit_cfg  = (paddr == usb_link_power_pkg::CFG_OFFSET);
   wire logic           hit_stat = (paddr == usb_link_power_pkg::STATUS_OFFSET);
   wire logic           unmapped = ~(hit_cfg | hit_stat);

   // Per-field write strobes honour the byte lanes carrying each field.
   // A write with pstrb[1] low leaves the three enables alone, so software
   // can retune the trim without a read-modify-write of the enables.
   // pstrb[3:2] carry no field here and are ignored.
   wire logic           lane_en  = pstrb[usb_link_power_pkg::LANE_ENABLES];
   wire logic           lane_tr  = pstrb[usb_link_power_pkg::LANE_TRIM];
   wire logic           wr_en_hi = wr_xfer & hit_cfg & lane_en;
   wire logic           wr_en_lo = wr_xfer & hit_cfg & lane_tr;

   // Either reset source restores the image (or defaults).
   // Held high for several cycles it simply reloads on every one of them;
   // no edge detection is needed because the reload is idempotent.
   wire logic           reload   = usb_reset | lite_reset;

   // Write data is sliced once here so every field instance sees plain bits.
   // Reserved positions therefore read back as zero whatever is written.
   // Write data slices; reserved bits 7 and 3:2 are simply not stored
   wire logic           wd_u1_init   = pwdata[usb_link_power_pkg::U1_INIT_BIT];
   wire logic           wd_u1_accept = pwdata[usb_link_power_pkg::U1_ACCEPT_BIT];
   wire logic           wd_ltm       = pwdata[usb_link_power_pkg::LTM_BIT];
   wire logic [2:0]     wd_fs_trim   =
      pwdata[usb_link_power_pkg::FS_TRIM_LSB +: usb_link_power_pkg::TRIM_W];

   // Field storage. Each bit or field is its own reload_field, so the
   // protection and the fallback default are chosen per field at the
   // instance and cannot drift apart between fields.
   // Device-initiated U1 enable: protected, image or zero on reload
   // Reload beats a same-cycle write unless rst_protect is high, so software cannot race
   // an unprotected link reset and end up with a half-applied value.
   reload_field #(
      .WIDTH          (1),
      .PROTECT        (1'b1),
      .DEFAULT        (usb_link_power_pkg::U1_INIT_DEFAULT)
   ) u_u1_init (
      .ref_clk        (ref_clk),
      .rst_b          (rst_b),
      .wr_en          (wr_en_hi),
      .wr_data        (wd_u1_init),
      .reload         (reload),
      .protect_active (rst_protect),
      .image_valid    (image_valid),
      .image_data     (image_u1_init),
      .value          (u1_self_initiate_en)
   );

   // Host-initiated U1 accept: protected, image or one on reload
   // Its default of one lets the host steer U1 entry before any driver runs.
   // It is independent of u1_self_initiate_en by construction.
   reload_field #(
      .WIDTH          (1),
      .PROTECT        (1'b1),
      .DEFAULT        (usb_link_power_pkg::U1_ACCEPT_DEFAULT)
   ) u_u1_accept (
      .ref_clk        (ref_clk),
      .rst_b          (rst_b),
      .wr_en          (wr_en_hi),
      .wr_data        (wd_u1_accept),
      .reload         (reload),
      .protect_active (rst_protect),
      .image_valid    (image_valid),
      .image_data     (image_u1_accept),
      .value          (u1_host_request_accept_en)
   );

   // Latency_tolerance_msg_en: protected, image or zero on reload
   // Stored here only; the LTM machinery itself lives in the controller,
   // which follows ltm_active one cycle after a write.
   reload_field #(
      .WIDTH          (1),
      .PROTECT        (1'b1),
      .DEFAULT        (usb_link_power_pkg::LTM_DEFAULT)
   ) u_ltm (
      .ref_clk        (ref_clk),
      .rst_b          (rst_b),
      .wr_en          (wr_en_hi),
      .wr_data        (wd_ltm),
      .reload         (reload),
      .protect_active (rst_protect),
      .image_valid    (image_valid),
      .image_data     (image_ltm),
      .value          (latency_tolerance_msg_en)
   );

   // Full-speed trim is not protected: every reload restores it.
   // The trim describes the PHY rather than a software policy, so the
   // protect input is wired for uniformity but has no effect here.
   reload_field #(
      .WIDTH          (usb_link_power_pkg::TRIM_W),
      .PROTECT        (1'b0),
      .DEFAULT        (usb_link_power_pkg::FS_TRIM_DEFAULT)
   ) u_fs_trim (
      .ref_clk        (ref_clk),
      .rst_b          (rst_b),
      .wr_en          (wr_en_lo),
      .wr_data        (wd_fs_trim),
      .reload         (reload),
      .protect_active (rst_protect),
      .image_valid    (image_valid),
      .image_data     (image_fs_trim),
      .value          (fullspeed_timeout_trim)
   );

   // Combinational trim selection and timeout sum.
   // The sum needs no saturation: the widest base plus the largest trim
   // still fits in eight bits of tenths.
   // Base and step are fixed at elaboration; only the trim moves at run time.
   logic [2:0]          calc_trim;     // Trim for the controller
   logic [7:0]          calc_tout;     // Timeout, tenths of a bit time

   fs_timeout_calc #(
      .FS_BASE_BITS      (FS_BASE_BITS)
   ) u_calc (
      .fs_trim           (fullspeed_timeout_trim),
      .hs_trim           (highspeed_timeout_trim),
      .fs_mode           (fs_mode),
      .presented_trim    (calc_trim),
      .fs_timeout_tenths (calc_tout)
   );

   // Each enable is derived from its own bit and no other field; no cross-gating.
   // The host feature gates only self-initiated entry; host-initiated
   // entry depends on the accept bit alone.
   wire logic           next_permit = u1_self_initiate_en & host_u1_feature_en;
   wire logic           next_accept = u1_host_request_accept_en;
   wire logic           next_ltm    = latency_tolerance_msg_en;

   // Control outputs are registered, so they lag a field change by one cycle.
   // The flops keep the controller's inputs glitch-free while the trim mux
   // switches with fs_mode; the lag is harmless at link time scales.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         // All-zero controller view while reset is held
         u1_initiate_permit     <= 1'b0;
         u1_host_accept         <= 1'b0;
         ltm_active             <= 1'b0;
         presented_timeout_trim <= 3'h0;
         fs_timeout_tenths      <= 8'h00;
      end else begin
         // Free-running copies of the next values
         u1_initiate_permit     <= next_permit;
         u1_host_accept         <= next_accept;
         ltm_active             <= next_ltm;
         presented_timeout_trim <= calc_trim;
         fs_timeout_tenths      <= calc_tout;
      end
   end

   // Configuration readback; all bits outside the fields read zero.
   // Built from package positions so a moved field needs a package edit only.
   // Reserved positions are never assigned, so they stay at zero.
   logic [31:0]         cfg_word;
   always_comb begin
      cfg_word = 32'h0000_0000;
      cfg_word[usb_link_power_pkg::U1_INIT_BIT]   = u1_self_initiate_en;
      cfg_word[usb_link_power_pkg::U1_ACCEPT_BIT] = u1_host_request_accept_en;
      cfg_word[usb_link_power_pkg::LTM_BIT]       = latency_tolerance_msg_en;
      cfg_word[usb_link_power_pkg::FS_TRIM_LSB +: usb_link_power_pkg::TRIM_W] =
         fullspeed_timeout_trim;
   end

   // Status view of what the controller is being told
   //   bit 0      u1_initiate_permit
   //   bit 1      u1_host_accept
   //   bit 2      ltm_active
   //   bit 3      fs_mode as seen now
   //   bit 4      image_valid
   //   bits 15:8  fs_timeout_tenths
   //   bits 18:16 presented_timeout_trim
   // Read-only; writes to it are dropped without an error.
   logic [31:0]         stat_word;
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[usb_link_power_pkg::ST_U1_PERMIT_BIT] = u1_initiate_permit;
      stat_word[usb_link_power_pkg::ST_U1_ACCEPT_BIT] = u1_host_accept;
      stat_word[usb_link_power_pkg::ST_LTM_BIT]       = ltm_active;
      stat_word[usb_link_power_pkg::ST_FS_MODE_BIT]   = fs_mode;
      stat_word[usb_link_power_pkg::ST_IMAGE_BIT]     = image_valid;
      stat_word[usb_link_power_pkg::ST_TOUT_LSB +: usb_link_power_pkg::TOUT_W] =
         fs_timeout_tenths;
      stat_word[usb_link_power_pkg::ST_TRIM_LSB +: usb_link_power_pkg::TRIM_W] =
         presented_timeout_trim;
   end

   // Read selection: unmapped addresses read zero
   // Only one register answers at a time, so a priority mux is safe.
   wire logic [31:0]    next_prdata = hit_cfg  ? cfg_word  :
                                      hit_stat ? stat_word : 32'h0000_0000;

   // Zero wait states; the slave is always ready
   // Every register is a plain flop or wire, so no access needs to stall.
   assign pready  = 1'b1;
   // Error only in the access phase of an unmapped transfer
   // Writes to unmapped addresses are dropped as well, since hit_cfg is low.
   assign pslverr = access & unmapped;

   // Read data captured in the setup cycle so it is a flop in the access phase.
   // It shows the fields as they stood at the setup edge; a reload landing
   // at that same edge shows up on the next read.
   // Between reads prdata holds, so idle bus cycles do not toggle it.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= next_prdata;
      end
   end
endmodule // usb_link_power_cfg_fields
`default_nettype wire

// File: rtl/usb_link_power_pkg.sv
// Constants for the USB link power configuration fields and their APB map.
// Assumes a 32-bit APB slave with byte addresses and a 60 MHz PHY clock.
package usb_link_power_pkg;
   // Bus geometry
   localparam int          ADDR_W            = 12;
   localparam int          DATA_W            = 32;
   localparam int          STRB_W            = 4;
   // Register byte addresses
   localparam logic [11:0] CFG_OFFSET        = 12'h084;  // usb_link_power_config
   localparam logic [11:0] STATUS_OFFSET     = 12'h0F0;  // link power status view
   // Configuration field positions
   localparam int          U1_INIT_BIT       = 10;
   localparam int          U1_ACCEPT_BIT     = 9;
   localparam int          LTM_BIT           = 8;
   localparam int          FS_TRIM_LSB       = 4;
   localparam int          TRIM_W            = 3;
   // Byte lanes that carry the fields
   localparam int          LANE_ENABLES      = 1;
   localparam int          LANE_TRIM         = 0;
   // Defaults when no image is available
   localparam logic        U1_INIT_DEFAULT   = 1'b0;
   localparam logic        U1_ACCEPT_DEFAULT = 1'b1;
   localparam logic        LTM_DEFAULT       = 1'b0;
   localparam logic [2:0]  FS_TRIM_DEFAULT   = 3'h0;
   // Full-speed timeout: base in bit times, step and result in tenths of a bit time
   localparam int          FS_BASE_MIN_BITS  = 16;
   localparam int          FS_BASE_MAX_BITS  = 18;
   localparam int          PHY_CLK_MHZ       = 60;
   localparam int          TENTHS_PER_BIT    = 10;
   localparam int          TENTHS_PER_PHYCLK = 2;    // 0.2 bit time at 60 MHz
   localparam int          TOUT_W            = 8;
   // Status register field positions
   localparam int          ST_U1_PERMIT_BIT  = 0;
   localparam int          ST_U1_ACCEPT_BIT  = 1;
   localparam int          ST_LTM_BIT        = 2;
   localparam int          ST_FS_MODE_BIT    = 3;
   localparam int          ST_IMAGE_BIT      = 4;
   localparam int          ST_TOUT_LSB       = 8;
   localparam int          ST_TRIM_LSB       = 16;
endpackage

// File: rtl/reload_field.sv
// One configuration field with write, reset reload and reset protection.
// Assumes reload requests and writes are synchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module reload_field #(
   parameter int              WIDTH   = 1,
   parameter bit              PROTECT = 1'b0,
   parameter logic [WIDTH-1:0] DEFAULT = '0
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // Software write
   input  wire logic             wr_en,
   input  wire logic [WIDTH-1:0] wr_data,
   // Reload source
   input  wire logic             reload,
   input  wire logic             protect_active,
   input  wire logic             image_valid,
   input  wire logic [WIDTH-1:0] image_data,
   // Field value
   output logic      [WIDTH-1:0] value
);
   // Protected fields ride through a reload while protection is on
   wire logic             reload_take = reload & ~(PROTECT & protect_active);
   // Image value, or fallback default while image_valid is low
   wire logic [WIDTH-1:0] reload_val  = image_valid ? image_data : DEFAULT;

   // A reload not blocked by protection beats a write in the same cycle: the reset defines the state
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         value <= DEFAULT;
      end else if (reload_take) begin
         value <= reload_val;
      end else if (wr_en) begin
         value <= wr_data;
      end
   end
endmodule // reload_field
`default_nettype wire

// File: rtl/fs_timeout_calc.sv
// Trim selection and full-speed inter-packet timeout arithmetic.
// Purely combinational; the caller registers the results.
`timescale 1ns/100ps
`default_nettype none
module fs_timeout_calc #(
   parameter int FS_BASE_BITS = usb_link_power_pkg::FS_BASE_MIN_BITS
) (
   // Mode and trims
   input  wire logic [2:0] fs_trim,
   input  wire logic [2:0] hs_trim,
   input  wire logic       fs_mode,
   // Results
   output logic      [2:0] presented_trim,
   output logic      [7:0] fs_timeout_tenths
);
   // Base held inside the standard window even if misconfigured
   localparam int BASE_CLAMP =
      (FS_BASE_BITS < usb_link_power_pkg::FS_BASE_MIN_BITS) ? usb_link_power_pkg::FS_BASE_MIN_BITS :
      (FS_BASE_BITS > usb_link_power_pkg::FS_BASE_MAX_BITS) ? usb_link_power_pkg::FS_BASE_MAX_BITS :
      FS_BASE_BITS;
   localparam logic [7:0] BASE_TENTHS = 8'(BASE_CLAMP * usb_link_power_pkg::TENTHS_PER_BIT);
   localparam logic [7:0] STEP_TENTHS = 8'(usb_link_power_pkg::TENTHS_PER_PHYCLK);

   // Outside full speed the high-speed trim goes to the controller
   assign presented_trim    = fs_mode ? fs_trim : hs_trim;
   // Trim count times per-clock factor, added to the base
   assign fs_timeout_tenths = 8'(BASE_TENTHS + 8'(fs_trim) * STEP_TENTHS);
endmodule // fs_timeout_calc
`default_nettype wire

// File: tb/usb_link_power_chk.sv
// Checker for the link power register bank, watching only its ports.
// Assumes one clock domain, ref_clk, with rst_b synchronous and active low.
`timescale 1ns/100ps
`default_nettype none
module usb_link_power_chk #(
   parameter int FS_BASE_BITS = 16
) (
   // Clock, reset and bus
   input  wire logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] prdata,
   // Reload and link inputs
   input  wire logic        usb_reset, lite_reset, rst_protect, image_valid,
   input  wire logic        host_u1_feature_en, fs_mode,
   input  wire logic [2:0]  highspeed_timeout_trim,
   // Controls
   input  wire logic        u1_initiate_permit, u1_host_accept, ltm_active,
   input  wire logic [2:0]  presented_timeout_trim,
   input  wire logic [7:0]  fs_timeout_tenths
);
   // Timeout span in tenths, trim adds at most 7 x 2
   localparam int TLO = FS_BASE_BITS * 10;
   localparam int THI = FS_BASE_BITS * 10 + 14;
   wire logic     wr  = psel && penable && pwrite;    // Write taken this edge
   wire logic     rl  = usb_reset || lite_reset;      // Any reload request
   wire logic     cfg = paddr == usb_link_power_pkg::CFG_OFFSET;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Protected reload with no write beside it
   sequence prot_rl; rst_protect && rl && !wr; endsequence
   // Plain reload to defaults, then a quiet cycle
   sequence rl_def; rl && !rst_protect && !image_valid ##1 !wr; endsequence
   ready_now_a: assert property (psel && penable |-> pready) else $error("pready low in access");
   unmapped_err_a: assert property (psel && penable |->
      pslverr == !(cfg || paddr == usb_link_power_pkg::STATUS_OFFSET)) else $error("pslverr wrong");
   permit_gate_a: assert property (u1_initiate_permit |-> $past(host_u1_feature_en))
      else $error("permit without host feature");
   hs_trim_a: assert property ($past(rst_b) && !$past(fs_mode) |->
      presented_timeout_trim == $past(highspeed_timeout_trim)) else $error("hs trim not shown");
   fs_tout_a: assert property ($past(rst_b) && $past(fs_mode) |->
      fs_timeout_tenths == 8'(TLO + 2 * presented_timeout_trim)) else $error("fs timeout sum wrong");
   base_span_a: assert property ($past(rst_b) |-> fs_timeout_tenths inside {[TLO:THI]})
      else $error("fs timeout out of span");
   protect_hold_a: assert property (prot_rl [*2] |=> $stable(ltm_active) && $stable(u1_host_accept))
      else $error("protected bits moved");
   reload_def_a: assert property (rl_def |=> u1_host_accept && !ltm_active && !u1_initiate_permit)
      else $error("reload defaults wrong");
   rsvd_zero_a: assert property (psel && penable && !pwrite && cfg |->
      prdata[31:11] == 21'h0 && prdata[7] == 1'b0 && prdata[3:0] == 4'h0) else $error("reserved bits set");
endmodule // usb_link_power_chk
bind usb_link_power_cfg_fields usb_link_power_chk #(.FS_BASE_BITS(FS_BASE_BITS)) u_chk (.*);
`default_nettype wire

// File: tb/host_port_model.sv
// Behavioural upstream host port: feature state, link speed and hs trim.
// Assumes the bench sets its wishes; changes land one edge later.
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // Wishes from the bench
   input  wire logic       want_u1,
   input  wire logic       want_fs,
   input  wire logic [2:0] want_hs,
   // Towards the block
   output var  logic       host_u1_feature_en,
   output var  logic       fs_mode,
   output var  logic [2:0] highspeed_timeout_trim
);
   // Registered like a real port, never combinational from the bench
   always_ff @(posedge ref_clk) begin
      host_u1_feature_en     <= rst_b ? want_u1 : 1'b0;
      fs_mode                <= rst_b ? want_fs : 1'b1;
      highspeed_timeout_trim <= rst_b ? want_hs : 3'h0;
   end
endmodule // host_port_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the link power register bank over APB.
// Assumes 100 ns clock and a registered host port model beside the block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'h0;
   logic        pready, pslverr, err, usb_reset = 0, lite_reset = 0, rst_protect = 0;
   logic        image_valid = 0, image_u1_init = 0, image_u1_accept = 0, image_ltm = 0;
   logic [2:0]  image_fs_trim = 3'h0, want_hs = 3'h0, highspeed_timeout_trim, presented_timeout_trim;
   logic        want_u1 = 0, want_fs = 1, host_u1_feature_en, fs_mode;
   logic        u1_initiate_permit, u1_host_accept, ltm_active;
   logic [7:0]  fs_timeout_tenths;
   int          n_mismatch = 0, compares = 0;
   localparam logic [11:0] CFG = usb_link_power_pkg::CFG_OFFSET;
   localparam logic [11:0] STAT = usb_link_power_pkg::STATUS_OFFSET;
   // Clock
   always #50 ref_clk = ~ref_clk;
   usb_link_power_cfg_fields u_dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .usb_reset, .lite_reset, .rst_protect, .image_valid,
      .image_u1_init, .image_u1_accept, .image_ltm, .image_fs_trim, .host_u1_feature_en, .fs_mode,
      .highspeed_timeout_trim, .u1_initiate_permit, .u1_host_accept, .ltm_active,
      .presented_timeout_trim, .fs_timeout_tenths);
   host_port_model u_host (.ref_clk, .rst_b, .want_u1, .want_fs, .want_hs, .host_u1_feature_en,
      .fs_mode, .highspeed_timeout_trim);
   // Compare one value
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer, waiting for pready under a bound
   task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge ref_clk) penable <= 1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge ref_clk);
   endtask
   // Let model and registered outputs settle, then compare the bundle
   task automatic outs(input logic p, a, l, input logic [2:0] t, input logic [7:0] to);
      repeat (3) @(posedge ref_clk);
      chk("outs", {18'h0, p, a, l, t, to},
          {18'h0, u1_initiate_permit, u1_host_accept, ltm_active, presented_timeout_trim, fs_timeout_tenths});
   endtask
   // One reload pulse of two cycles
   task automatic reload(input bit lite);
      if (lite) lite_reset <= 1; else usb_reset <= 1;
      repeat (2) @(posedge ref_clk);
      lite_reset <= 0; usb_reset <= 0;
      @(posedge ref_clk);
   endtask
   task automatic t_defaults;
      apb(0, CFG, 0, 4'h0); chk("cfg", 32'h0000_0200, rd);
      outs(0, 1, 0, 3'h0, 8'hA0);
   endtask
   task automatic t_fields;
      apb(1, CFG, 32'hFFFF_FFFF, 4'hF);
      apb(0, CFG, 0, 4'h0); chk("cfg", 32'h0000_0770, rd);
      outs(0, 1, 1, 3'h7, 8'hAE);
      want_u1 <= 1; outs(1, 1, 1, 3'h7, 8'hAE);
      apb(1, CFG, 32'h0000_0400, 4'hF); outs(1, 0, 0, 3'h0, 8'hA0);
      apb(1, CFG, 32'h0000_0200, 4'hF); outs(0, 1, 0, 3'h0, 8'hA0);
   endtask
   task automatic t_strobes;
      apb(1, CFG, 32'hFFFF_FFFF, 4'h1); apb(0, CFG, 0, 4'h0); chk("cfg", 32'h0000_0270, rd);
      apb(1, CFG, 32'h0, 4'h2); apb(0, CFG, 0, 4'h0); chk("cfg", 32'h0000_0070, rd);
      apb(0, 12'h100, 0, 4'h0); chk("err", 32'h1, {31'h0, err}); chk("rd", 32'h0, rd);
      apb(1, STAT, 32'hFFFF_FFFF, 4'hF); chk("err", 32'h0, {31'h0, err});
      apb(0, CFG, 0, 4'h0); chk("cfg", 32'h0000_0070, rd);
      apb(0, STAT, 0, 4'h0); chk("stat", 32'h0007_AE08, rd);
   endtask
   task automatic t_hs;
      want_fs <= 0;
      for (int i = 0; i < 8; i++) begin
         want_hs <= 3'(i); outs(0, 0, 0, 3'(i), 8'hAE);
      end
      want_fs <= 1; outs(0, 0, 0, 3'h7, 8'hAE);
   endtask
   task automatic t_reload;
      apb(1, CFG, 32'h0000_0770, 4'hF);
      image_valid <= 1; image_fs_trim <= 3'h5; rst_protect <= 1;
      reload(0); apb(0, CFG, 0, 4'h0); chk("cfg", 32'h0000_0750, rd);
      rst_protect <= 0;
      reload(1); apb(0, CFG, 0, 4'h0); chk("cfg", 32'h0000_0050, rd);
      image_valid <= 0;
      reload(0); apb(0, CFG, 0, 4'h0); chk("cfg", 32'h0000_0200, rd);
   endtask
   // Verdict and end of run
   task automatic final_report;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog, far beyond the hundred or so cycles the run needs
   initial begin
      #2_000_000;
      n_mismatch++;
      final_report;
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_b <= 1;
      @(posedge ref_clk);
      t_defaults; t_fields; t_strobes; t_hs; t_reload;
      final_report;
   end
endmodule // tb_top
`default_nettype wire
